// ### bench/udic_host_model.sv
// Host side model: line level, bus reset, resume, frame and endpoint events.
// Assumes the bench calls its tasks; all drives follow the rising edge.
`timescale 1ns/1ps

module udic_host_model
    import udic_pkg::*;
(
    // Clock
    input wire logic clk,
    // Events toward the block
    output logic line_idle,
    output logic usb_bus_reset,
    output logic resume_end,
    output udic_sof_s sof,
    output udic_ep_ev_s ep_ev
);
    initial begin
        line_idle = 1'b0;
        usb_bus_reset = 1'b0;
        resume_end = 1'b0;
        sof = '0;
        ep_ev = '0;
    end

    // ==========================================
    // One-cycle frame token, frame kept after
    task automatic sof_tok(input logic [10:0] f, input logic bad);
        @(posedge clk);
        sof <= '{valid: 1'b1, crc_bad: bad, frame: f};
        @(posedge clk);
        sof.valid <= 1'b0;
    endtask

    task automatic ep_pulse(input udic_ep_ev_s e);
        @(posedge clk);
        ep_ev <= e;
        @(posedge clk);
        ep_ev <= '0;
    endtask

    task automatic host_resume_end();
        @(posedge clk);
        resume_end <= 1'b1;
        @(posedge clk);
        resume_end <= 1'b0;
    endtask

    task automatic bus_reset(input int n);
        @(posedge clk);
        usb_bus_reset <= 1'b1;
        repeat (n) @(posedge clk);
        usb_bus_reset <= 1'b0;
    endtask

    task automatic idle(input logic v);
        @(posedge clk);
        line_idle <= v;
    endtask
endmodule

// ### bench/udic_top_tb_top.sv
// Self-checking bench for the device interrupt and control block.
// Assumes the host model drives events; bench masters the register bus.
`timescale 1ns/1ps

module udic_top_tb_top
    import udic_pkg::*;
;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic clk_en = 1'b1;
    logic [5:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = '0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic line_idle, usb_bus_reset, resume_end;
    udic_sof_s sof;
    udic_ep_ev_s ep_ev;
    udic_pad_s pad;
    logic [6:0] addr_v;
    logic addr_act, usb_irq, endpoint_irq;
    logic [6:0] buf_clr, ep_act, halt_rq, halt_cn, tog;
    logic [6:0] seen_cn = '0, seen_tog = '0;
    int fails = 0, compares = 0, cyc = 0;

    always #4 clk = ~clk;

    udic_host_model i_host (.clk(clk), .line_idle(line_idle),
        .usb_bus_reset(usb_bus_reset), .resume_end(resume_end),
        .sof(sof), .ep_ev(ep_ev));

    udic_top #(.SUSPEND_CYC(20), .RESUME_CYC(10)) i_dut (.clk(clk),
        .arst_n(arst_n), .clk_en(clk_en), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .line_idle(line_idle),
        .usb_bus_reset(usb_bus_reset), .resume_end(resume_end),
        .sof(sof), .ep_ev(ep_ev), .pad(pad), .device_addr_value(addr_v),
        .address_activate(addr_act), .endpoint_buffer_clear(buf_clr),
        .endpoint_active(ep_act), .halt_handshake_request(halt_rq),
        .halt_handshake_cancel(halt_cn), .toggle_zero_force(tog),
        .usb_irq(usb_irq), .endpoint_irq(endpoint_irq));

    // Pulse catchers for self-clearing controls
    always @(posedge clk) begin
        seen_cn <= seen_cn | halt_cn;
        seen_tog <= seen_tog | tog;
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            fails++;
            tally_and_finish();
        end
    end

    // ==========================================
    // Helpers
    task automatic tally_and_finish();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t seen %h expected %h",
                $time, seen, exp);
        end
    endtask

    task automatic bus(input logic w, input logic [5:0] a,
        input logic [7:0] d, output logic [31:0] q);
        @(posedge clk);
        avs_read <= !w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= {24'h0000_00, d};
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, q);
        chk(q, {24'h0000_00, e});
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // ==========================================
    // Scenarios
    task automatic t_reset();
        rd(OFS_DEV_IEN, 8'h08);
        rd(OFS_DEV_FLAGS, 8'h00);
        rd(6'h3C, 8'h00);
        wr(OFS_DEV_CTRL, 8'hFA);
        rd(OFS_DEV_CTRL, 8'h00);
        $display("done reset");
    endtask

    task automatic t_frame();
        i_host.sof_tok(11'h5A3, 1'b1);
        tick(2);
        chk(usb_irq, 1'b0);
        rd(OFS_FRAME_NUMBER_HI, 8'h05);
        rd(OFS_FRAME_NUMBER_LO, 8'hA3);
        rd(OFS_FRAME_STAT, 8'h10);
        rd(OFS_DEV_FLAGS, 8'h04);
        wr(OFS_DEV_IEN, 8'h0C);
        tick(1);
        chk(usb_irq, 1'b1);
        wr(OFS_DEV_FLAGS, 8'hFF);
        rd(OFS_DEV_FLAGS, 8'h04);
        i_host.sof_tok(11'h002, 1'b0);
        tick(2);
        rd(OFS_FRAME_STAT, 8'h00);
        rd(OFS_FRAME_NUMBER_LO, 8'h02);
        wr(OFS_DEV_FLAGS, 8'h00);
        tick(1);
        chk(usb_irq, 1'b0);
        $display("done frame");
    endtask

    task automatic t_suspend();
        i_host.idle(1'b1);
        tick(30);
        rd(OFS_DEV_FLAGS, 8'h01);
        i_host.idle(1'b0);
        tick(4);
        rd(OFS_DEV_FLAGS, 8'h11);
        wr(OFS_DEV_CTRL, 8'h02);
        tick(2);
        chk(pad.resume_drive, 1'b1);
        wr(OFS_DEV_CTRL, 8'h00);
        rd(OFS_DEV_FLAGS, 8'h51);
        rd(OFS_DEV_CTRL, 8'h02);
        tick(8);
        chk(pad.resume_drive, 1'b0);
        rd(OFS_DEV_CTRL, 8'h00);
        i_host.host_resume_end();
        tick(1);
        rd(OFS_DEV_FLAGS, 8'h71);
        wr(OFS_DEV_FLAGS, 8'h00);
        rd(OFS_DEV_FLAGS, 8'h00);
        $display("done suspend");
    endtask

    task automatic t_endpoint();
        udic_ep_ev_s e;
        wr(OFS_EP_RST, 8'hFF);
        tick(1);
        chk(buf_clr, 7'h7F);
        rd(OFS_EP_RST, 8'h7F);
        wr(OFS_EP_RST, 8'h00);
        wr(OFS_EP_SEL, 8'hFA);
        rd(OFS_EP_SEL, 8'h02);
        wr(OFS_EP_CTRL, 8'h21);
        wr(OFS_EP_CTRL, 8'h01);
        chk({halt_rq[2], ep_act[2]}, 2'b11);
        rd(OFS_EP_CTRL, 8'h21);
        e = '0;
        e.setup_rcv[2] = 1'b1;
        i_host.ep_pulse(e);
        tick(1);
        chk(halt_rq, 7'h00);
        wr(OFS_EP_CTRL, 8'h19);
        tick(2);
        chk({seen_cn, seen_tog}, {7'h04, 7'h04});
        rd(OFS_EP_CTRL, 8'h01);
        e = '0;
        e.overrun[2] = 1'b1;
        e.stall_sent[2] = 1'b1;
        i_host.ep_pulse(e);
        tick(1);
        rd(OFS_EP_FLAGS, 8'h0A);
        rd(OFS_EP_STAT, 8'h40);
        chk(endpoint_irq, 1'b0);
        wr(OFS_EP_IEN, 8'h80);
        tick(1);
        chk(endpoint_irq, 1'b1);
        wr(OFS_EP_STAT, 8'h00);
        wr(OFS_EP_FLAGS, 8'h00);
        e = '0;
        e.iso_crc_err[2] = 1'b1;
        i_host.ep_pulse(e);
        tick(1);
        chk(endpoint_irq, 1'b0);
        rd(OFS_EP_FLAGS, 8'h02);
        wr(OFS_EP_SEL, 8'h07);
        rd(OFS_EP_CTRL, 8'h00);
        $display("done endpoint");
    endtask

    task automatic t_address();
        wr(OFS_DEV_ADDR, 8'h05);
        wr(OFS_DEV_ADDR, 8'h85);
        wr(OFS_DEV_ADDR, 8'h05);
        chk({addr_act, addr_v}, 8'h85);
        i_host.bus_reset(3);
        tick(2);
        chk({addr_act, ep_act}, 8'h00);
        rd(OFS_DEV_FLAGS, 8'h08);
        chk(usb_irq, 1'b1);
        wr(OFS_DEV_FLAGS, 8'h00);
        $display("done address");
    endtask

    task automatic t_pullup();
        wr(OFS_LINK_CTRL, 8'h01);
        tick(1);
        chk(pad[2:1], 2'b10);
        wr(OFS_DEV_CTRL, 8'h04);
        tick(1);
        chk(pad[2:1], 2'b01);
        wr(OFS_DEV_CTRL, 8'h05);
        tick(1);
        chk(pad[2:1], 2'b00);
        $display("done pullup");
    endtask

    // Frame token while frozen must leave no trace
    task automatic t_freeze();
        clk_en <= 1'b0;
        i_host.sof_tok(11'h3C1, 1'b1);
        tick(2);
        clk_en <= 1'b1;
        rd(OFS_FRAME_NUMBER_LO, 8'h02);
        rd(OFS_DEV_FLAGS, 8'h00);
        rd(OFS_FRAME_STAT, 8'h00);
        $display("done freeze");
    endtask

    initial begin
        tick(2);
        arst_n <= 1'b1;
        tick(1);
        t_reset();
        t_frame();
        t_suspend();
        t_endpoint();
        t_address();
        t_pullup();
        t_freeze();
        tally_and_finish();
    end
endmodule

// ### design/udic_pkg.sv
// Constants, carriers and state layout of the USB device interrupt
// and control block.
// Assumes a 125 MHz controller clock and an Avalon-MM register port.

package udic_pkg;

    // ==================================================================
    // Sizes and timing
    localparam int EP_COUNT = 7;
    localparam int CNT_W = 20;
    localparam int CLK_MHZ = 125;
    localparam int SUSPEND_TIME_US = 3000;
    localparam int SUSPEND_CYCLES = SUSPEND_TIME_US * CLK_MHZ;
    localparam int RESUME_TIME_US = 2000;
    localparam int RESUME_CYCLES = RESUME_TIME_US * CLK_MHZ;

    // ==================================================================
    // Register byte offsets
    localparam logic [5:0] OFS_DEV_CTRL = 6'h00;
    localparam logic [5:0] OFS_DEV_FLAGS = 6'h04;
    localparam logic [5:0] OFS_DEV_IEN = 6'h08;
    localparam logic [5:0] OFS_DEV_ADDR = 6'h0C;
    localparam logic [5:0] OFS_FRAME_NUMBER_HI = 6'h10;
    localparam logic [5:0] OFS_FRAME_NUMBER_LO = 6'h14;
    localparam logic [5:0] OFS_FRAME_STAT = 6'h18;
    localparam logic [5:0] OFS_EP_SEL = 6'h1C;
    localparam logic [5:0] OFS_EP_RST = 6'h20;
    localparam logic [5:0] OFS_EP_CTRL = 6'h24;
    localparam logic [5:0] OFS_LINK_CTRL = 6'h28;
    localparam logic [5:0] OFS_EP_FLAGS = 6'h2C;
    localparam logic [5:0] OFS_EP_STAT = 6'h30;
    localparam logic [5:0] OFS_EP_IEN = 6'h34;

    // ==================================================================
    // Field positions
    localparam int B_LOW_SPEED = 2;
    localparam int B_REMOTE_WAKE = 1;
    localparam int B_DETACH = 0;
    localparam int B_UPRSM = 6;
    localparam int B_EORSM = 5;
    localparam int B_WAKE = 4;
    localparam int B_EORST = 3;
    localparam int B_SOF = 2;
    localparam int B_SUSP = 0;
    localparam int B_ADDR_EN = 7;
    localparam int B_CRC_ERR = 4;
    localparam int B_HALT_REQ = 5;
    localparam int B_HALT_CANCEL = 4;
    localparam int B_TOGGLE_ZERO = 3;
    localparam int B_EP_ACTIVE = 0;
    localparam int B_CONNECT = 0;
    localparam int B_FLOW_EN = 7;
    localparam int B_OVERRUN = 6;
    localparam int B_UNDERRUN = 5;

    // ==================================================================
    // Masks and reset values
    localparam logic [7:0] GEN_FLAG_MASK = 8'h7D;
    localparam logic [7:0] GEN_IEN_RESET = 8'h08;
    localparam logic [7:0] EP_INT_MASK = 8'h5F;
    localparam logic [7:0] EP_IEN_MASK = 8'hDF;
    localparam logic [2:0] EP_SEL_FORBIDDEN = 3'h7;

    // ==================================================================
    // Carriers
    typedef struct packed {
        logic valid;
        logic crc_bad;
        logic [10:0] frame;
    } udic_sof_s;

    typedef struct packed {
        logic [EP_COUNT-1:0] in_free;
        logic [EP_COUNT-1:0] out_rcv;
        logic [EP_COUNT-1:0] setup_rcv;
        logic [EP_COUNT-1:0] stall_sent;
        logic [EP_COUNT-1:0] iso_crc_err;
        logic [EP_COUNT-1:0] overrun;
        logic [EP_COUNT-1:0] underrun;
        logic [EP_COUNT-1:0] nak_in;
        logic [EP_COUNT-1:0] nak_out;
    } udic_ep_ev_s;

    typedef struct packed {
        logic pullup_dp;
        logic pullup_dm;
        logic resume_drive;
    } udic_pad_s;

    typedef struct packed {
        logic waitrequest;
        logic [31:0] readdata;
        logic [2:0] dev_ctrl;
        logic connect;
        logic [7:0] gen_flags;
        logic [7:0] gen_ien;
        logic addr_active;
        logic [6:0] addr;
        logic [10:0] frame;
        logic crc_err;
        logic [2:0] ep_sel;
        logic [EP_COUNT-1:0] ep_rst;
        logic [EP_COUNT-1:0] ep_active;
        logic [EP_COUNT-1:0] halt_req;
        logic [EP_COUNT-1:0] halt_cancel;
        logic [EP_COUNT-1:0] toggle_zero;
        logic [EP_COUNT-1:0][7:0] ep_int;
        logic [EP_COUNT-1:0][7:0] ep_ien;
        logic [EP_COUNT-1:0][1:0] ep_err;
        logic [CNT_W-1:0] idle_cnt;
        logic [CNT_W-1:0] resume_cnt;
        logic idle_meta;
        logic idle_sync;
        logic idle_prev;
        logic bus_reset_prev;
        udic_pad_s pad;
        logic usb_irq;
        logic ep_irq;
    } udic_state_s;

    localparam udic_state_s STATE_RESET = '{
        waitrequest: 1'b1,
        gen_ien: GEN_IEN_RESET,
        default: '0
    };

endpackage

// ### design/udic_top.sv
// USB device interrupt sources, device and endpoint control registers.
// Assumes event pulses from the USB engine on clk, the idle line level
// from the pad, and an Avalon-MM master on the register port.
//
// Added by the designer: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps

module udic_top
    import udic_pkg::*;
#(
    parameter int SUSPEND_CYC = SUSPEND_CYCLES,
    parameter int RESUME_CYC = RESUME_CYCLES
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clk_en,
    // Avalon-MM slave
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // USB line and engine events
    input wire logic line_idle,
    input wire logic usb_bus_reset,
    input wire logic resume_end,
    input wire udic_sof_s sof,
    input wire udic_ep_ev_s ep_ev,
    // Pad control
    output udic_pad_s pad,
    // Device and endpoint control
    output logic [6:0] device_addr_value,
    output logic address_activate,
    output logic [EP_COUNT-1:0] endpoint_buffer_clear,
    output logic [EP_COUNT-1:0] endpoint_active,
    output logic [EP_COUNT-1:0] halt_handshake_request,
    output logic [EP_COUNT-1:0] halt_handshake_cancel,
    output logic [EP_COUNT-1:0] toggle_zero_force,
    // Interrupt requests
    output logic usb_irq,
    output logic endpoint_irq
);

    // ==================================================================
    // Elaboration checks
    if (SUSPEND_CYC < 2 || SUSPEND_CYC >= 2 ** CNT_W) begin : g_bad_susp
        $error("SUSPEND_CYC out of range");
    end
    if (RESUME_CYC < 2 || RESUME_CYC >= 2 ** CNT_W) begin : g_bad_res
        $error("RESUME_CYC out of range");
    end

    localparam logic [CNT_W-1:0] SUSP_LAST = CNT_W'(SUSPEND_CYC - 1);
    localparam logic [CNT_W-1:0] SUSP_DONE = CNT_W'(SUSPEND_CYC);
    localparam logic [CNT_W-1:0] RES_LAST = CNT_W'(RESUME_CYC - 1);

    udic_state_s r;
    udic_state_s next_r;
    logic req;
    logic wr_take;
    logic sel_ok;
    logic [2:0] s;
    logic [7:0] wd;
    logic [7:0] rd;
    logic [7:0] ev_int;
    logic [1:0] ev_err;
    logic [EP_COUNT-1:0] ep_hit;

    assign req = avs_read | avs_write;
    assign wr_take = avs_write & ~r.waitrequest;
    assign sel_ok = r.ep_sel != EP_SEL_FORBIDDEN;
    assign s = r.ep_sel;
    assign wd = avs_writedata[7:0];

    // ==================================================================
    // Read multiplexer, reserved bits zero
    always_comb begin
        rd = 8'h00;
        case (avs_address)
            OFS_DEV_CTRL: rd = {5'h00, r.dev_ctrl};
            OFS_DEV_FLAGS: rd = r.gen_flags & GEN_FLAG_MASK;
            OFS_DEV_IEN: rd = r.gen_ien & GEN_FLAG_MASK;
            OFS_DEV_ADDR: rd = {r.addr_active, r.addr};
            OFS_FRAME_NUMBER_HI: rd = {5'h00, r.frame[10:8]};
            OFS_FRAME_NUMBER_LO: rd = r.frame[7:0];
            OFS_FRAME_STAT: rd = {3'h0, r.crc_err, 4'h0};
            OFS_EP_SEL: rd = {5'h00, r.ep_sel};
            OFS_EP_RST: rd = {1'b0, r.ep_rst};
            OFS_LINK_CTRL: rd = {7'h00, r.connect};
            OFS_EP_CTRL: begin
                if (sel_ok) begin
                    rd = {2'h0, r.halt_req[s], 4'h0, r.ep_active[s]};
                end
            end
            OFS_EP_FLAGS: begin
                if (sel_ok) begin
                    rd = r.ep_int[s] & EP_INT_MASK;
                end
            end
            OFS_EP_STAT: begin
                if (sel_ok) begin
                    rd = {1'b0, r.ep_err[s], 5'h00};
                end
            end
            OFS_EP_IEN: begin
                if (sel_ok) begin
                    rd = r.ep_ien[s] & EP_IEN_MASK;
                end
            end
            default: rd = 8'h00;
        endcase
    end

    // ==================================================================
    // Next state
    always_comb begin
        next_r = r;
        ev_int = 8'h00;
        ev_err = 2'h0;
        ep_hit = '0;

        // Line idle synchroniser
        next_r.idle_meta = line_idle;
        next_r.idle_sync = r.idle_meta;
        next_r.idle_prev = r.idle_sync;
        next_r.bus_reset_prev = usb_bus_reset;
        next_r.halt_cancel = '0;
        next_r.toggle_zero = '0;

        // Bus handshake: one wait state, then accept
        next_r.waitrequest = 1'b1;
        if (req && r.waitrequest) begin
            next_r.waitrequest = 1'b0;
            next_r.readdata = {24'h00_0000, rd};
        end

        // Register writes
        if (wr_take) begin
            case (avs_address)
                OFS_DEV_CTRL: begin
                    next_r.dev_ctrl[B_LOW_SPEED] = wd[B_LOW_SPEED];
                    next_r.dev_ctrl[B_DETACH] = wd[B_DETACH];
                    if (wd[B_REMOTE_WAKE] && r.gen_flags[B_SUSP]) begin
                        next_r.dev_ctrl[B_REMOTE_WAKE] = 1'b1;
                    end
                end
                OFS_DEV_FLAGS: begin
                    next_r.gen_flags = r.gen_flags & wd;
                end
                OFS_DEV_IEN: next_r.gen_ien = wd & GEN_FLAG_MASK;
                OFS_DEV_ADDR: begin
                    next_r.addr = wd[6:0];
                    if (wd[B_ADDR_EN]) begin
                        next_r.addr_active = 1'b1;
                    end
                end
                OFS_EP_SEL: next_r.ep_sel = wd[2:0];
                OFS_EP_RST: next_r.ep_rst = wd[6:0];
                OFS_LINK_CTRL: next_r.connect = wd[B_CONNECT];
                OFS_EP_CTRL: begin
                    if (sel_ok) begin
                        next_r.ep_active[s] = wd[B_EP_ACTIVE];
                        if (wd[B_HALT_REQ]) begin
                            next_r.halt_req[s] = 1'b1;
                        end
                        if (wd[B_HALT_CANCEL]) begin
                            next_r.halt_req[s] = 1'b0;
                            next_r.halt_cancel[s] = 1'b1;
                        end
                        if (wd[B_TOGGLE_ZERO]) begin
                            next_r.toggle_zero[s] = 1'b1;
                        end
                    end
                end
                OFS_EP_FLAGS: begin
                    if (sel_ok) begin
                        next_r.ep_int[s] = r.ep_int[s] & wd;
                    end
                end
                OFS_EP_STAT: begin
                    if (sel_ok) begin
                        next_r.ep_err[s] = r.ep_err[s] & wd[6:5];
                    end
                end
                OFS_EP_IEN: begin
                    if (sel_ok) begin
                        next_r.ep_ien[s] = wd & EP_IEN_MASK;
                    end
                end
                default: ;
            endcase
        end

        // Start of frame, events set after clears so set wins
        if (sof.valid) begin
            next_r.gen_flags[B_SOF] = 1'b1;
            next_r.frame = sof.frame;
            next_r.crc_err = sof.crc_bad;
        end

        // Suspend detection on a steady idle line
        if (!r.idle_sync) begin
            next_r.idle_cnt = '0;
        end else if (r.idle_cnt != SUSP_DONE) begin
            next_r.idle_cnt = r.idle_cnt + 1'b1;
            if (r.idle_cnt == SUSP_LAST) begin
                next_r.gen_flags[B_SUSP] = 1'b1;
            end
        end

        // Line activity after suspend, not our own resume
        if (r.idle_prev && !r.idle_sync && r.idle_cnt == SUSP_DONE &&
            !r.pad.resume_drive) begin
            next_r.gen_flags[B_WAKE] = 1'b1;
        end

        if (resume_end) begin
            next_r.gen_flags[B_EORSM] = 1'b1;
        end

        // Bus reset clears device state; its end raises a flag
        if (usb_bus_reset) begin
            next_r.addr_active = 1'b0;
            next_r.addr = 7'h00;
            next_r.ep_active = '0;
            next_r.halt_req = '0;
        end
        if (r.bus_reset_prev && !usb_bus_reset) begin
            next_r.gen_flags[B_EORST] = 1'b1;
        end

        // Upstream resume signalling
        next_r.pad.resume_drive = 1'b0;
        if (r.dev_ctrl[B_REMOTE_WAKE]) begin
            next_r.pad.resume_drive = 1'b1;
            next_r.gen_flags[B_UPRSM] = 1'b1;
            if (!r.pad.resume_drive) begin
                next_r.resume_cnt = '0;
            end else if (r.resume_cnt == RES_LAST) begin
                next_r.pad.resume_drive = 1'b0;
                next_r.dev_ctrl[B_REMOTE_WAKE] = 1'b0;
            end else begin
                next_r.resume_cnt = r.resume_cnt + 1'b1;
            end
        end

        // Pull-up selection
        next_r.pad.pullup_dp = next_r.connect &
            ~next_r.dev_ctrl[B_DETACH] & ~next_r.dev_ctrl[B_LOW_SPEED];
        next_r.pad.pullup_dm = next_r.connect &
            ~next_r.dev_ctrl[B_DETACH] & next_r.dev_ctrl[B_LOW_SPEED];

        // Endpoint events
        for (int i = 0; i < EP_COUNT; i++) begin
            ev_int = {1'b0, ep_ev.nak_in[i], 1'b0, ep_ev.nak_out[i],
                ep_ev.setup_rcv[i], ep_ev.out_rcv[i],
                ep_ev.stall_sent[i] | ep_ev.iso_crc_err[i],
                ep_ev.in_free[i]};
            ev_err = {ep_ev.overrun[i], ep_ev.underrun[i]};
            next_r.ep_int[i] = next_r.ep_int[i] | ev_int;
            next_r.ep_err[i] = next_r.ep_err[i] | ev_err;
            if (ep_ev.setup_rcv[i]) begin
                next_r.halt_req[i] = 1'b0;
            end
            ep_hit[i] = |(next_r.ep_int[i] & next_r.ep_ien[i] &
                EP_INT_MASK) |
                (next_r.ep_ien[i][B_FLOW_EN] & |next_r.ep_err[i]);
        end

        next_r.usb_irq = |(next_r.gen_flags & next_r.gen_ien &
            GEN_FLAG_MASK);
        next_r.ep_irq = |ep_hit;
    end

    // ==================================================================
    // State register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            r <= STATE_RESET;
        end else if (clk_en) begin
            r <= next_r;
        end
    end

    assign avs_readdata = r.readdata;
    assign avs_waitrequest = r.waitrequest;
    assign pad = r.pad;
    assign device_addr_value = r.addr;
    assign address_activate = r.addr_active;
    assign endpoint_buffer_clear = r.ep_rst;
    assign endpoint_active = r.ep_active;
    assign halt_handshake_request = r.halt_req;
    assign halt_handshake_cancel = r.halt_cancel;
    assign toggle_zero_force = r.toggle_zero;
    assign usb_irq = r.usb_irq;
    assign endpoint_irq = r.ep_irq;

    // ==================================================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_sof_flag_set: assert property (
        clk_en && sof.valid |=> r.gen_flags[B_SOF])
        else $error("frame flag not set");

    a_frame_capture: assert property (
        clk_en && sof.valid |=> r.frame == $past(sof.frame))
        else $error("frame number not captured");

    a_crc_with_sof: assert property (
        clk_en && sof.valid |=> r.crc_err == $past(sof.crc_bad) &&
            r.gen_flags[B_SOF])
        else $error("crc flag not updated with frame flag");

    a_suspend_time: assert property (
        $rose(r.gen_flags[B_SUSP]) |-> $past(r.idle_cnt) == SUSP_LAST)
        else $error("suspend flag at wrong time");

    a_usb_irq_gate: assert property (
        usb_irq == |(r.gen_flags & r.gen_ien & GEN_FLAG_MASK))
        else $error("usb interrupt not matching flags");

    a_wake_needs_susp: assert property (
        $rose(r.dev_ctrl[B_REMOTE_WAKE]) |-> $past(r.gen_flags[B_SUSP]))
        else $error("remote wake set without suspend");

    a_resume_flag: assert property (
        $rose(pad.resume_drive) |-> r.gen_flags[B_UPRSM])
        else $error("resume driven without flag");

    a_pullup_select: assert property (
        !(pad.pullup_dp && pad.pullup_dm) &&
        (pad.pullup_dm == (r.connect && !r.dev_ctrl[B_DETACH] &&
            r.dev_ctrl[B_LOW_SPEED])))
        else $error("wrong pull-up selected");

    a_addr_hw_clear: assert property (
        $fell(address_activate) |-> $past(usb_bus_reset))
        else $error("address enable cleared without bus reset");

    a_setup_halt: assert property (
        clk_en && ep_ev.setup_rcv[2] |=> !halt_handshake_request[2])
        else $error("halt request kept after setup");

    a_toggle_pulse: assert property (
        clk_en && toggle_zero_force[2] |=> !toggle_zero_force[2])
        else $error("toggle force longer than one cycle");

    a_halt_sent: assert property (
        clk_en && (ep_ev.stall_sent[2] || ep_ev.iso_crc_err[2])
        |=> r.ep_int[2][1])
        else $error("halt sent flag not set");

endmodule
